// file: cfd_pkg.sv
// constants for the can fd bit-timing block: offsets, fields, resets, timing
// assumes a 20 MHz system clock; every module except the transceiver model imports the whole package
package cfd_pkg;
   // clock and bit-time figures, in ns
   localparam int CLK_PERIOD_NS = 50;
   localparam int QUANTUM_NS = 50;
   localparam int NOM_BIT_NS = 2000;
   localparam int NOM_MIN_NS = 1992;
   localparam int NOM_MAX_NS = 2008;
   localparam int DAT_BIT_NS = 500;
   localparam int DAT_MIN_NS = 498;
   localparam int DAT_MAX_NS = 502;
   // total clock tolerance in tenths of a percent (+/-0.4 %)
   localparam int TOL_PERMIL = 4;
   // least times round up, longest times round down
   localparam logic [15:0] NOM_MIN_CLK = 16'((NOM_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] NOM_MAX_CLK = 16'(NOM_MAX_NS / CLK_PERIOD_NS);
   localparam logic [15:0] DAT_MIN_CLK = 16'((DAT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] DAT_MAX_CLK = 16'(DAT_MAX_NS / CLK_PERIOD_NS);
   localparam logic [7:0] PRESC_RST = 8'(QUANTUM_NS / CLK_PERIOD_NS);
   // timing-set reset values
   localparam logic [7:0] NOM_NQ_RST = 8'h28;
   localparam logic [7:0] NOM_SEG2_RST = 8'h08;
   localparam logic [7:0] NOM_SJW_RST = 8'h08;
   localparam logic [7:0] DAT_NQ_RST = 8'h0a;
   localparam logic [7:0] DAT_SEG2_RST = 8'h02;
   localparam logic [7:0] DAT_SJW_RST = 8'h02;
   localparam logic [7:0] MIN_SEG2 = 8'h02;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PRESC = 8'h04;
   localparam logic [7:0] OFS_NOM = 8'h08;
   localparam logic [7:0] OFS_DAT = 8'h0c;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_SPT = 8'h14;
   // field positions
   localparam int F_NQ = 0;
   localparam int F_SEG2 = 8;
   localparam int F_SJW = 16;
   localparam int C_EN = 0;
   localparam int C_FD = 1;
   localparam int S_NOM_REJ = 0;
   localparam int S_DAT_REJ = 1;
   localparam int S_NOM_RANGE = 2;
   localparam int S_DAT_RANGE = 3;
   localparam int S_DPHASE = 4;
   localparam int S_RXBIT = 5;
   localparam int S_RUN = 6;
   localparam int SPT_DAT = 8;
   typedef enum logic [1:0] {ST_OFF, ST_HUNT, ST_RUN} cfd_state_t;
endpackage

// file: cfd_seg_if.sv
// carrier between the register decode and one timing-set holder
// the holder owns the stored fields; the decode only writes and reads
`timescale 1ns/1ps
interface cfd_seg_if;
   logic wr;
   logic [23:0] wdata;
   logic [7:0] quanta_per_bit;
   logic [7:0] seg2;
   logic [7:0] sjw;
   logic reject;
   modport owner (input wr, input wdata, output quanta_per_bit, output seg2, output sjw,
      output reject);
   modport user (output wr, output wdata, input quanta_per_bit, input seg2, input sjw,
      input reject);
endinterface

// file: cfd_seg_reg.sv
// one bit-timing set: quanta per bit, segment two and jump width
// assumes wr is a one-cycle strobe from the register decode
`timescale 1ns/1ps
module cfd_seg_reg
   import cfd_pkg::*;
#(
   parameter logic [7:0] NQ_RST = NOM_NQ_RST,
   parameter logic [7:0] SEG2_RST = NOM_SEG2_RST,
   parameter logic [7:0] SJW_RST = NOM_SJW_RST
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // register side
   cfd_seg_if.owner seg
);
   logic [7:0] nq_q;
   logic [7:0] seg2_q;
   logic [7:0] sjw_q;
   wire [7:0] nq_w = seg.wdata[F_NQ +: 8];
   wire [7:0] seg2_w = seg.wdata[F_SEG2 +: 8];
   wire [7:0] sjw_w = seg.wdata[F_SJW +: 8];
   // segment one must keep at least one quantum
   wire seg1_ok = {1'b0, nq_w} >= ({1'b0, seg2_w} + 9'h002);
   wire ok = (seg2_w >= sjw_w) && (seg2_w >= MIN_SEG2) && (sjw_w != 8'h00) && seg1_ok;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         nq_q <= NQ_RST;
         seg2_q <= SEG2_RST;
         sjw_q <= SJW_RST;
      end else if (seg.wr && ok) begin
         nq_q <= nq_w;
         seg2_q <= seg2_w;
         sjw_q <= sjw_w;
      end
   end

   assign seg.quanta_per_bit = nq_q;
   assign seg.seg2 = seg2_q;
   assign seg.sjw = sjw_q;
   // a refused write leaves the old set in force
   assign seg.reject = seg.wr && !ok;
endmodule // cfd_seg_reg

// file: cfd_bit_timing.sv
// bit-timing generator for a can / can fd controller: quantum prescaler,
// nominal and data bit sets, hard sync, resync, single sampling point
// assumes a 20 MHz clock, rx_pin from a transceiver, frame control from the controller
//
// Overview of operation
// - nominal bit defaults to 2000 ns, flagged outside 1992 to 2008 ns
// - fd data bit after rate switch defaults to 500 ns, limits 498-502 ns
// - classical frames stay on nominal timing for every bit
// - both bit periods programmable as whole multiples of the clock period
// - limits hold a total tolerance of plus or minus 0.4 percent
// - one quantum length serves both phases; only quanta per bit, segment two and jump width differ
// - exactly one sample per bit decides its value
// - reset set: 50 ns quantum, 40/8/8 nominal, 10/2/2 data
// - 100 ns quantum set 20/4/4 and 5/2/2 is accepted too
// - resync lengthens or shortens a bit by at most the jump width
// - every node samples at the same percentage of the bit
// - nominal target stays 2000 ns; offsets count as frequency error
`timescale 1ns/1ps
module cfd_bit_timing
   import cfd_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // controller side
   input wire logic bus_idle,
   input wire logic fd_frame,
   input wire logic rate_switch,
   input wire logic rate_return,
   input wire logic tx_bit,
   output logic bit_start,
   output logic sample_strobe,
   output logic rx_value,
   output logic data_phase,
   // transceiver side
   input wire logic rx_pin,
   output logic tx_pin
);
   // register decode
   wire sel_ctrl = reg_addr == OFS_CTRL;
   wire sel_presc = reg_addr == OFS_PRESC;
   wire sel_nom = reg_addr == OFS_NOM;
   wire sel_dat = reg_addr == OFS_DAT;
   wire sel_stat = reg_addr == OFS_STAT;
   wire sel_spt = reg_addr == OFS_SPT;

   cfd_seg_if nom_if ();
   cfd_seg_if dat_if ();

   assign nom_if.wr = reg_wr && sel_nom;
   assign nom_if.wdata = reg_wdata[23:0];
   assign dat_if.wr = reg_wr && sel_dat;
   assign dat_if.wdata = reg_wdata[23:0];

   cfd_seg_reg #(
      .NQ_RST(NOM_NQ_RST),
      .SEG2_RST(NOM_SEG2_RST),
      .SJW_RST(NOM_SJW_RST)
   ) u_nom (
      .clock(clock),
      .nrst(nrst),
      .seg(nom_if.owner)
   );

   cfd_seg_reg #(
      .NQ_RST(DAT_NQ_RST),
      .SEG2_RST(DAT_SEG2_RST),
      .SJW_RST(DAT_SJW_RST)
   ) u_dat (
      .clock(clock),
      .nrst(nrst),
      .seg(dat_if.owner)
   );

   // control and status registers
   logic en_q;
   logic fd_en_q;
   logic [7:0] presc_q;
   logic nom_rej_q;
   logic dat_rej_q;
   logic [31:0] rdata_q;

   // a zero prescale would stop the quantum clock, so it is held at one
   wire [7:0] presc_w = (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0];
   wire stat_clr = reg_wr && sel_stat;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         en_q <= 1'b0;
         fd_en_q <= 1'b0;
         presc_q <= PRESC_RST;
      end else begin
         if (reg_wr && sel_ctrl) begin
            en_q <= reg_wdata[C_EN];
            fd_en_q <= reg_wdata[C_FD];
         end
         if (reg_wr && sel_presc) begin
            presc_q <= presc_w;
         end
      end
   end

   // sticky refusal flags, write one to clear; a new refusal wins
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         nom_rej_q <= 1'b0;
         dat_rej_q <= 1'b0;
      end else begin
         nom_rej_q <= nom_if.reject || (nom_rej_q && !(stat_clr && reg_wdata[S_NOM_REJ]));
         dat_rej_q <= dat_if.reject || (dat_rej_q && !(stat_clr && reg_wdata[S_DAT_REJ]));
      end
   end

   // programmed bit lengths in clocks, checked against the tolerance window
   wire [15:0] nom_clk = presc_q * nom_if.quanta_per_bit;
   wire [15:0] dat_clk = presc_q * dat_if.quanta_per_bit;
   // any programming offset shows here as a deviation, the target stays fixed
   wire nom_range = (nom_clk < NOM_MIN_CLK) || (nom_clk > NOM_MAX_CLK);
   wire dat_range = (dat_clk < DAT_MIN_CLK) || (dat_clk > DAT_MAX_CLK);

   // sample position as a percentage, for matching all nodes of a subnet
   wire [15:0] nom_spt_num = 16'(nom_if.quanta_per_bit - nom_if.seg2) * 16'd100;
   wire [15:0] dat_spt_num = 16'(dat_if.quanta_per_bit - dat_if.seg2) * 16'd100;
   wire [15:0] nom_spt = nom_spt_num / {8'h00, nom_if.quanta_per_bit};
   wire [15:0] dat_spt = dat_spt_num / {8'h00, dat_if.quanta_per_bit};

   // line side: two-stage synchroniser, then an edge history stage
   logic rx_meta_q;
   logic rx_sync_q;
   logic rx_prev_q;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
         rx_prev_q <= 1'b1;
      end else begin
         rx_meta_q <= rx_pin;
         rx_sync_q <= rx_meta_q;
         rx_prev_q <= rx_sync_q;
      end
   end

   // recessive to dominant transition
   wire fall = rx_prev_q && !rx_sync_q;

   // timing state
   cfd_state_t state_q;
   cfd_state_t state_d;
   logic [7:0] pcnt_q;
   logic [8:0] qcnt_q;
   logic [8:0] end_q;
   logic phase_q;
   logic sw_pend_q;
   logic ret_pend_q;
   logic resynced_q;
   logic bit_start_q;
   logic sample_q;
   logic rx_value_q;
   logic tx_q;

   // one prescaler serves both phases, so the quantum never changes length
   wire tick = (state_q == ST_RUN) && (pcnt_q == presc_q - 8'h01);

   // active set follows the phase; only quanta per bit, segments and jump width change
   wire [7:0] nq = phase_q ? dat_if.quanta_per_bit : nom_if.quanta_per_bit;
   wire [7:0] seg2 = phase_q ? dat_if.seg2 : nom_if.seg2;
   wire [7:0] sjw = phase_q ? dat_if.sjw : nom_if.sjw;
   wire [8:0] nq_last = {1'b0, nq} - 9'h001;
   // segment one is what remains after the sync quantum and segment two
   wire [8:0] seg1 = nq_last - {1'b0, seg2};

   // resynchronisation, once per bit, only after a recessive sample
   wire run_edge = (state_q == ST_RUN) && fall;
   wire hard = run_edge && bus_idle;
   wire resync = run_edge && !bus_idle && !resynced_q && rx_value_q && (qcnt_q != 9'h000);
   wire early = qcnt_q <= seg1;
   wire [8:0] lag = (qcnt_q < {1'b0, sjw}) ? qcnt_q : {1'b0, sjw};
   wire [8:0] lead = {1'b0, nq} - qcnt_q;
   wire lengthen = resync && early;
   wire short_now = resync && !early && (lead <= {1'b0, sjw});
   wire short_sjw = resync && !early && (lead > {1'b0, sjw});
   // never more than one jump width either way
   wire [8:0] end_cur = lengthen ? (nq_last + lag) :
                        short_sjw ? (nq_last - {1'b0, sjw}) : end_q;
   // a late edge inside the jump width starts the next bit at once
   wire restart = hard || short_now;
   wire bit_end = restart || (tick && (qcnt_q == end_cur));

   // the single sampling instant at the close of segment one
   wire sample_now = tick && !restart && (qcnt_q == seg1);

   // phase chosen at each boundary; classical frames never leave nominal
   logic phase_d;
   always_comb begin
      phase_d = phase_q;
      if (!fd_frame || !fd_en_q) begin
         phase_d = 1'b0;
      end else if (sw_pend_q) begin
         phase_d = 1'b1;
      end else if (ret_pend_q) begin
         phase_d = 1'b0;
      end
   end
   wire [8:0] end_next = {1'b0, (phase_d ? dat_if.quanta_per_bit : nom_if.quanta_per_bit)} - 9'h001;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_OFF: begin
            if (en_q) begin
               state_d = ST_HUNT;
            end
         end
         ST_HUNT: begin
            if (!en_q) begin
               state_d = ST_OFF;
            end else if (fall) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!en_q) begin
               state_d = ST_OFF;
            end
         end
         default: begin
            state_d = ST_OFF;
         end
      endcase
   end

   wire hunt_sync = (state_q == ST_HUNT) && en_q && fall;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_q <= ST_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // quantum prescaler, realigned on every hard sync and on a bit restart
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pcnt_q <= 8'h00;
      end else if (restart || hunt_sync || tick || state_q != ST_RUN) begin
         pcnt_q <= 8'h00;
      end else begin
         pcnt_q <= pcnt_q + 8'h01;
      end
   end

   // quantum position within the bit and the bit's last quantum
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         qcnt_q <= 9'h000;
         end_q <= {1'b0, NOM_NQ_RST} - 9'h001;
      end else if (hunt_sync || bit_end) begin
         qcnt_q <= 9'h000;
         end_q <= end_next;
      end else begin
         if (tick) begin
            qcnt_q <= qcnt_q + 9'h001;
         end
         if (lengthen || short_sjw) begin
            end_q <= end_cur;
         end
      end
   end

   // rate switch requests wait for the next boundary; a new request wins
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sw_pend_q <= 1'b0;
         ret_pend_q <= 1'b0;
         phase_q <= 1'b0;
      end else begin
         sw_pend_q <= rate_switch || (sw_pend_q && !bit_end);
         ret_pend_q <= rate_return || (ret_pend_q && !bit_end);
         if (state_q != ST_RUN) begin
            phase_q <= 1'b0;
         end else if (bit_end) begin
            phase_q <= phase_d;
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         resynced_q <= 1'b0;
      end else if (bit_end || hunt_sync) begin
         resynced_q <= 1'b0;
      end else if (resync) begin
         resynced_q <= 1'b1;
      end
   end

   // strobes, sampled value and transmit bit
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bit_start_q <= 1'b0;
         sample_q <= 1'b0;
         rx_value_q <= 1'b1;
         tx_q <= 1'b1;
      end else begin
         bit_start_q <= bit_end || hunt_sync;
         sample_q <= sample_now;
         if (sample_now) begin
            rx_value_q <= rx_sync_q;
         end
         if (state_q == ST_OFF) begin
            tx_q <= 1'b1;
         end else if (bit_end || hunt_sync) begin
            tx_q <= tx_bit;
         end
      end
   end

   // read mux; unmapped addresses read as zero
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0000_0000;
      if (sel_ctrl) begin
         rmux[C_EN] = en_q;
         rmux[C_FD] = fd_en_q;
      end else if (sel_presc) begin
         rmux[7:0] = presc_q;
      end else if (sel_nom) begin
         rmux[23:0] = {nom_if.sjw, nom_if.seg2, nom_if.quanta_per_bit};
      end else if (sel_dat) begin
         rmux[23:0] = {dat_if.sjw, dat_if.seg2, dat_if.quanta_per_bit};
      end else if (sel_stat) begin
         rmux[S_NOM_REJ] = nom_rej_q;
         rmux[S_DAT_REJ] = dat_rej_q;
         rmux[S_NOM_RANGE] = nom_range;
         rmux[S_DAT_RANGE] = dat_range;
         rmux[S_DPHASE] = phase_q;
         rmux[S_RXBIT] = rx_value_q;
         rmux[S_RUN] = state_q == ST_RUN;
      end else if (sel_spt) begin
         rmux[7:0] = nom_spt[7:0];
         rmux[SPT_DAT +: 8] = dat_spt[7:0];
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 32'h0000_0000;
      end else if (reg_rd) begin
         rdata_q <= rmux;
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end

   assign reg_rdata = rdata_q;
   assign bit_start = bit_start_q;
   assign sample_strobe = sample_q;
   assign rx_value = rx_value_q;
   assign data_phase = phase_q;
   assign tx_pin = tx_q;
endmodule // cfd_bit_timing

// file: cfd_bit_timing_chk.sv
// port assertions for the can fd bit-timing block
// assumes one clock domain; bound to the top module below
`timescale 1ns/1ps
module cfd_bit_timing_chk
   import cfd_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // controller side
   input wire logic fd_frame,
   input wire logic tx_bit,
   input wire logic bit_start,
   input wire logic sample_strobe,
   input wire logic rx_value,
   input wire logic data_phase,
   // transceiver side
   input wire logic tx_pin
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   // set once the current bit has been sampled
   logic sampled_q;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sampled_q <= 1'b0;
      end else if (bit_start) begin
         sampled_q <= 1'b0;
      end else if (sample_strobe) begin
         sampled_q <= 1'b1;
      end
   end
   wire logic nom_bad;
   assign nom_bad = reg_wr && reg_addr == OFS_NOM
      && (reg_wdata[15:8] < reg_wdata[23:16] || reg_wdata[15:8] < MIN_SEG2);
   AST_RST_IDLE: assert property ($rose(nrst) |-> tx_pin && rx_value && !data_phase)
      else $error("outputs not idle after reset");
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   AST_STAT_LIVE: assert property ($past(reg_rd) && $past(reg_addr) == OFS_STAT
      |-> reg_rdata[S_RXBIT] == $past(rx_value) && reg_rdata[S_DPHASE] == $past(data_phase))
      else $error("status does not mirror sampled bit or phase");
   AST_NOM_REJECT: assert property (nom_bad ##1 !reg_wr ##1 reg_rd && reg_addr == OFS_STAT
      |=> reg_rdata[S_NOM_REJ])
      else $error("bad nominal set not flagged");
   AST_ONE_SAMPLE: assert property (sample_strobe |-> !sampled_q)
      else $error("second sample in one bit");
   AST_RX_AT_SAMPLE: assert property ($changed(rx_value) |-> sample_strobe)
      else $error("bit value changed without a sample");
   AST_TX_AT_START: assert property ($changed(tx_pin) |-> bit_start && tx_pin == $past(tx_bit))
      else $error("transmit changed off a bit start");
   AST_FD_ONLY: assert property ($rose(data_phase) |-> $past(fd_frame))
      else $error("data phase in a classical frame");
   AST_PHASE_AT_START: assert property ($changed(data_phase)
      |-> (bit_start || $past(bit_start)) or (##1 bit_start))
      else $error("phase changed inside a bit");
   AST_NO_OVERLAP: assert property (!(bit_start && sample_strobe))
      else $error("sample in the sync quantum");
   COV_DATA_BIT: cover property (bit_start && data_phase);
   COV_LOW_SAMPLE: cover property (sample_strobe && !rx_value);
   COV_REJECT: cover property (nom_bad);
endmodule // cfd_bit_timing_chk

bind cfd_bit_timing cfd_bit_timing_chk cfd_bit_timing_chk_inst (.clock(clock), .nrst(nrst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .fd_frame(fd_frame), .tx_bit(tx_bit), .bit_start(bit_start),
   .sample_strobe(sample_strobe), .rx_value(rx_value), .data_phase(data_phase),
   .tx_pin(tx_pin));

// file: cfd_xcvr_model.sv
// behavioural transceiver and bus: our transmitter and one other node
// assumes other_dom comes from the bench, high while that node drives dominant
`timescale 1ns/1ps
module cfd_xcvr_model #(
   parameter int LOOP_NS = 100
) (
   // logic side
   input wire logic tx_pin,
   output logic rx_pin,
   // other node
   input wire logic other_dom
);
   // dominant wins; a released bus is pulled recessive by the termination
   wire logic bus_level;
   assign bus_level = tx_pin & ~other_dom;
   initial rx_pin = 1'b1;
   // transport delay so short glitches are not swallowed
   always @(bus_level) begin
      rx_pin <= #(LOOP_NS) bus_level;
   end
endmodule // cfd_xcvr_model

// file: cfd_bit_timing_tb.sv
// self-checking bench for the can fd bit-timing block
// assumes the transceiver model loops tx_pin back to rx_pin
`timescale 1ns/1ps
module cfd_bit_timing_tb;
   import cfd_pkg::*;
   localparam logic [31:0] NOM_DEF = {8'h00, NOM_SJW_RST, NOM_SEG2_RST, NOM_NQ_RST};
   localparam logic [31:0] DAT_DEF = {8'h00, DAT_SJW_RST, DAT_SEG2_RST, DAT_NQ_RST};
   localparam logic [31:0] ST_IDLE = 32'h1 << S_RXBIT;
   localparam logic [31:0] ST_DATA = ST_IDLE | (32'h1 << S_RUN) | (32'h1 << S_DPHASE);
   // sample point sits at (nq - seg2) / nq of the bit
   localparam logic [31:0] SPT_DEF = {16'h0, 8'((DAT_NQ_RST - DAT_SEG2_RST) * 100 / DAT_NQ_RST),
      8'((NOM_NQ_RST - NOM_SEG2_RST) * 100 / NOM_NQ_RST)};
   localparam int NOM_SMP = (NOM_NQ_RST - NOM_SEG2_RST) * QUANTUM_NS;
   localparam int DAT_SMP = (DAT_NQ_RST - DAT_SEG2_RST) * QUANTUM_NS;
   localparam int LONG_NS = (NOM_NQ_RST + NOM_SJW_RST) * QUANTUM_NS;
   // a late edge may cut a bit by at most the jump width
   localparam int SHORT_MIN_NS = (NOM_NQ_RST - NOM_SJW_RST) * QUANTUM_NS;
   localparam int SHORT_MAX_NS = (NOM_NQ_RST - 1) * QUANTUM_NS;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, bus_idle = 1'b0, fd_frame = 1'b0;
   logic rate_switch = 1'b0, rate_return = 1'b0, tx_bit = 1'b1, other_dom = 1'b0;
   logic [31:0] reg_rdata, rd;
   logic bit_start, sample_strobe, rx_value, data_phase, rx_pin, tx_pin;
   int n_errors = 0, num_checks = 0, t_samp, t_bit;

   cfd_bit_timing cfd_bit_timing_inst (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .bus_idle(bus_idle), .fd_frame(fd_frame), .rate_switch(rate_switch),
      .rate_return(rate_return), .tx_bit(tx_bit), .bit_start(bit_start),
      .sample_strobe(sample_strobe), .rx_value(rx_value), .data_phase(data_phase),
      .rx_pin(rx_pin), .tx_pin(tx_pin));
   cfd_xcvr_model cfd_xcvr_model_inst (.tx_pin(tx_pin), .rx_pin(rx_pin), .other_dom(other_dom));

   initial begin
      forever #25 clock = ~clock;
   end

   task automatic tick();
      @(posedge clock);
      #1;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_ns(input int clocks, input int lo, input int hi);
      num_checks++;
      if (clocks * CLK_PERIOD_NS < lo || clocks * CLK_PERIOD_NS > hi) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, clocks * CLK_PERIOD_NS, lo);
      end
   endtask
   // strobe dropped with a spare cycle so back-to-back calls never collide
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      tick();
      reg_wr <= 1'b0;
      tick();
   endtask
   task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      tick();
      reg_rd <= 1'b0;
      rd = reg_rdata;
      tick();
      chk_val(rd, e);
   endtask
   task automatic wait_evt(input bit on_sample, output int n);
      n = 1;
      tick();
      while ((on_sample ? sample_strobe : bit_start) !== 1'b1) begin
         n++;
         if (n > 400) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, 0, 1);
            summarize();
         end
         tick();
      end
   endtask
   // one whole bit: start to sample, start to next start
   task automatic measure();
      wait_evt(1'b0, t_bit);
      wait_evt(1'b1, t_samp);
      wait_evt(1'b0, t_bit);
      t_bit += t_samp;
   endtask
   task automatic request(input bit to_data);
      rate_switch <= to_data;
      rate_return <= !to_data;
      tick();
      rate_switch <= 1'b0;
      rate_return <= 1'b0;
   endtask

   initial begin
      repeat (3) tick();
      nrst <= 1'b1;
      tick();
      expect_reg(OFS_PRESC, 32'h1);
      expect_reg(OFS_NOM, NOM_DEF);
      expect_reg(OFS_DAT, DAT_DEF);
      expect_reg(OFS_SPT, SPT_DEF);
      expect_reg(OFS_STAT, ST_IDLE);
      reg_write(8'h18, 32'hffffffff);
      expect_reg(8'h18, 32'h0);
      $display("test reset_values done");
      reg_write(OFS_NOM, 32'h080428);
      expect_reg(OFS_STAT, ST_IDLE | 32'h1);
      reg_write(OFS_DAT, 32'h01010a);
      expect_reg(OFS_NOM, NOM_DEF);
      expect_reg(OFS_STAT, ST_IDLE | 32'h3);
      reg_write(OFS_STAT, 32'h3);
      expect_reg(OFS_STAT, ST_IDLE);
      $display("test reject done");
      reg_write(OFS_NOM, 32'h101050);
      reg_write(OFS_DAT, 32'h040414);
      expect_reg(OFS_NOM, 32'h101050);
      expect_reg(OFS_STAT, ST_IDLE | 32'hc);
      expect_reg(OFS_SPT, SPT_DEF);
      reg_write(OFS_PRESC, 32'h2);
      reg_write(OFS_NOM, 32'h040414);
      reg_write(OFS_DAT, 32'h020205);
      expect_reg(OFS_STAT, ST_IDLE);
      reg_write(OFS_PRESC, 32'h0);
      expect_reg(OFS_PRESC, 32'h1);
      reg_write(OFS_NOM, NOM_DEF);
      reg_write(OFS_DAT, DAT_DEF);
      $display("test settings done");
      reg_write(OFS_CTRL, 32'h3);
      bus_idle <= 1'b1;
      other_dom <= 1'b1;
      wait_evt(1'b0, t_bit);
      bus_idle <= 1'b0;
      repeat (10) tick();
      other_dom <= 1'b0;
      measure();
      chk_ns(t_samp, NOM_SMP, NOM_SMP);
      chk_ns(t_bit, NOM_MIN_NS, NOM_MAX_NS);
      chk_ns(t_bit, NOM_BIT_NS, NOM_BIT_NS);
      request(1'b1);
      measure();
      chk_ns(t_bit, NOM_BIT_NS, NOM_BIT_NS);
      chk_val(data_phase, 1'b0);
      $display("test nominal done");
      fd_frame <= 1'b1;
      request(1'b1);
      wait_evt(1'b0, t_bit);
      measure();
      chk_ns(t_bit, DAT_MIN_NS, DAT_MAX_NS);
      chk_ns(t_samp, DAT_SMP, DAT_SMP);
      chk_val(data_phase, 1'b1);
      expect_reg(OFS_STAT, ST_DATA);
      request(1'b0);
      wait_evt(1'b0, t_bit);
      measure();
      chk_ns(t_bit, NOM_BIT_NS, NOM_BIT_NS);
      chk_val(data_phase, 1'b0);
      $display("test data_phase done");
      repeat (20) tick();
      other_dom <= 1'b1;
      wait_evt(1'b0, t_bit);
      chk_ns(t_bit + 20, LONG_NS, LONG_NS);
      wait_evt(1'b1, t_samp);
      chk_val(rx_value, 1'b0);
      other_dom <= 1'b0;
      wait_evt(1'b0, t_bit);
      // edge lands in segment two after a recessive sample
      repeat (29) tick();
      other_dom <= 1'b1;
      wait_evt(1'b0, t_bit);
      chk_ns(t_bit + 29, SHORT_MIN_NS, SHORT_MAX_NS);
      other_dom <= 1'b0;
      tx_bit <= 1'b0;
      wait_evt(1'b0, t_bit);
      chk_val(tx_pin, 1'b0);
      $display("test resync done");
      summarize();
   end
endmodule // cfd_bit_timing_tb
